/* design/sep_pkg.sv */
package sep_pkg;

    // Core clock
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // Least deselect time, rounded up to whole cycles
    localparam int T_CSL_NS = 250;
    localparam int CSL_CYC = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] CSL_CYC_W = 3'(CSL_CYC);

    // Longest program cycle times, in ms and in cycles (rounded down)
    localparam int T_WC_MS = 10;
    localparam int T_EC_MS = 15;
    localparam int T_WL_MS = 30;
    localparam int WC_CYC_DEF = T_WC_MS * (CLK_HZ / 1000);
    localparam int EC_CYC_DEF = T_EC_MS * (CLK_HZ / 1000);
    localparam int WL_CYC_DEF = T_WL_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 20;

    // Frame geometry
    localparam int SH_W = 26;
    localparam int MEM_DEPTH = 128;
    localparam logic [4:0] AW16 = 5'h07;
    localparam logic [4:0] AW8 = 5'h08;
    localparam logic [4:0] DW16 = 5'h10;
    localparam logic [4:0] DW8 = 5'h08;
    localparam logic [4:0] OPC_LEN = 5'h02;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Opcodes and extended sub-codes
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_DIS = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL_CMD = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL_CMD = 2'h2;
    localparam logic [1:0] EXT_EN = 2'h3;

    // Command engine states, Gray along idle-shift-read-done
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_READ = 2'h3,
        ST_DONE = 2'h2
    } sep_state_t;

endpackage

/* design/sep_prog_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sep_prog_timer
    import sep_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [TMR_W-1:0] load,
    output logic busy
);

    // Remaining cycles of the self-timed program cycle
    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;

    // Load on start, count down otherwise; select has no say
    assign cnt_d = start ? load :
                   (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    assign busy = (cnt_q != '0);

    // Countdown register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    count_down_a: assert property (busy && !start |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("program timer did not count down");
    start_load_a: assert property (start |=> cnt_q == $past(load))
        else $error("program timer did not load its limit");
    busy_hold_a: assert property ($rose(busy) |-> busy[*8])
        else $error("program cycle cut short");

endmodule // sep_prog_timer
`default_nettype wire

/* design/sep_port.sv */
// Function
// - Select high active, low means standby once not busy
// - Program cycle finishes regardless of select
// - Select low resets command logic
// - Bits sampled and shifted on rising clock
// - Clock may pause at either level
// - Clock ignored while select low
// - Waiting for start, clocks change nothing
// - Exact bit count, then ignore until deselect
// - Read drives addressed word bit by bit
// - Status shown when select rises after deselect while busy
// - No status if select constant; else high-Z
// - Width select low 8-bit, high 16-bit
// - Program cycle within 10/15/30 ms
// - Start is first edge with input high
// - Status low busy, high ready
// - Dummy zero precedes first read bit
// - Output released when select falls
`timescale 1ns/1ps
`default_nettype none
module sep_port
    import sep_pkg::*;
#(
    parameter int unsigned WC_CYC = WC_CYC_DEF,
    parameter int unsigned EC_CYC = EC_CYC_DEF,
    parameter int unsigned WL_CYC = WL_CYC_DEF
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic device_select,
    input wire logic serial_clock,
    input wire logic serial_in_line,
    input wire logic word_width_select,
    output logic serial_out_line,
    output logic serial_out_oe_n,
    output logic standby
);
    // Reset release synchroniser
    logic rst_q1, rst_q2, rst_n;
    // Pin synchronisers
    logic cs_s1, cs_s2, ck_s1, ck_s2, ck_s3;
    logic di_s1, di_s2, org_s1, org_s2;
    // Command engine
    sep_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d, cnt_n;
    logic [SH_W-1:0] sh_q, sh_n;
    logic [1:0] op_q;
    logic [7:0] addr_q;
    // Read path
    logic [15:0] rd_sh_q;
    logic [4:0] rd_cnt_q, rd_cnt_n;
    logic drive_q, out_bit_q;
    // Programming control and status
    logic wr_en_q, status_q, cs_prev_q, busy;
    logic [2:0] desel_cnt_q;
    // Word memory, 16 bits per entry
    logic [15:0] mem [MEM_DEPTH];
    // Release reset through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    assign rst_n = rst_q2;
    // Two-flop synchronisers for every pin, third stage for clock edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {cs_s1, cs_s2, ck_s1, ck_s2, ck_s3} <= 5'h00;
            {di_s1, di_s2, org_s1, org_s2} <= 4'h0;
        end else begin
            {cs_s1, cs_s2} <= {device_select, cs_s1};
            {ck_s1, ck_s2, ck_s3} <= {serial_clock, ck_s1, ck_s2};
            {di_s1, di_s2} <= {serial_in_line, di_s1};
            {org_s1, org_s2} <= {word_width_select, org_s1};
        end
    end
    // Decode of edges, width and frame lengths
    wire rise = ck_s2 & ~ck_s3;
    wire sclk_edge = cs_s2 & rise;
    wire x16 = org_s2;
    wire [4:0] hdr_len = OPC_LEN + (x16 ? AW16 : AW8);
    wire [4:0] dw = x16 ? DW16 : DW8;
    wire [4:0] full_len = hdr_len + dw;
    wire in_shift = (state_q == ST_SHIFT) && sclk_edge;
    wire in_read = (state_q == ST_READ) && sclk_edge;
    wire start_det = (state_q == ST_IDLE) && sclk_edge && di_s2;
    assign cnt_n = cnt_q + 5'h01;
    assign sh_n = {sh_q[SH_W-2:0], di_s2};
    wire at_hdr = in_shift && (cnt_n == hdr_len);
    wire at_full = in_shift && (cnt_n == full_len);
    // Field extraction from the header or data field just completed
    wire [1:0] op_n = x16 ? sh_n[8:7] : sh_n[9:8];
    wire [1:0] ext_n = x16 ? sh_n[6:5] : sh_n[7:6];
    wire [7:0] addr_n = x16 ? {1'b0, sh_n[6:0]} : sh_n[7:0];
    wire [15:0] data_n = x16 ? sh_n[15:0] : {8'h00, sh_n[7:0]};
    wire is_ext = (op_n == OP_EXT);
    wire needs_data = (op_n == OP_WRITE) || (is_ext && ext_n == EXT_WRITE_ALL_CMD);
    // Command strobes; programming gated by enable and idle timer
    wire can_prog = wr_en_q & ~busy;
    wire read_go = at_hdr && (op_n == OP_READ);
    wire en_cmd = at_hdr && is_ext && (ext_n == EXT_EN);
    wire dis_cmd = at_hdr && is_ext && (ext_n == EXT_DIS);
    wire erase_go = at_hdr && (op_n == OP_ERASE) && can_prog;
    wire erase_all_cmd_go = at_hdr && is_ext && (ext_n == EXT_ERASE_ALL_CMD) && can_prog;
    wire write_go = at_full && (op_q == OP_WRITE) && can_prog;
    wire write_all_cmd_go = at_full && (op_q == OP_EXT) && can_prog;
    wire prog_go = erase_go | erase_all_cmd_go | write_go | write_all_cmd_go;
    wire [TMR_W-1:0] prog_load = write_all_cmd_go ? TMR_W'(WL_CYC) :
                                 erase_all_cmd_go ? TMR_W'(EC_CYC) :
                                 TMR_W'(WC_CYC);
    // Word addressing: x8 uses bit 0 as byte select
    wire [6:0] rd_idx = x16 ? addr_n[6:0] : addr_n[7:1];
    wire [6:0] wr_idx = x16 ? addr_q[6:0] : addr_q[7:1];
    wire [15:0] rd_word_raw = mem[rd_idx];
    wire [7:0] rd_byte = addr_n[0] ? rd_word_raw[15:8] : rd_word_raw[7:0];
    wire [15:0] rd_word = x16 ? rd_word_raw : {rd_byte, 8'h00};
    wire [15:0] old_word = mem[wr_idx];
    wire [15:0] merged = x16 ? data_n :
                         addr_q[0] ? {data_n[7:0], old_word[7:0]} :
                         {old_word[15:8], data_n[7:0]};
    wire [15:0] all_word = x16 ? data_n : {data_n[7:0], data_n[7:0]};
    // Next state of the command engine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_det) begin
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (at_hdr) begin
                    state_d = read_go ? ST_READ :
                              needs_data ? ST_SHIFT : ST_DONE;
                end else if (at_full) begin
                    state_d = ST_DONE;
                end
            end
            ST_READ: begin
                if (in_read && rd_cnt_n == dw) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: state_d = ST_DONE;
        endcase
        if (!cs_s2) begin
            state_d = ST_IDLE;
        end
    end
    assign rd_cnt_n = rd_cnt_q + 5'h01;
    assign cnt_d = in_shift ? cnt_n :
                   (state_q == ST_IDLE) ? 5'h00 : cnt_q;
    // Engine state, bit counter, input shifter and header capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            sh_q <= '0;
            op_q <= OP_EXT;
            addr_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (in_shift) begin
                sh_q <= sh_n;
            end
            if (at_hdr) begin
                op_q <= op_n;
                addr_q <= addr_n;
            end
        end
    end
    // Read shifter: dummy zero first, then data MSB first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_sh_q <= 16'h0000;
            rd_cnt_q <= 5'h00;
            out_bit_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (!cs_s2) begin
            drive_q <= 1'b0;
        end else if (read_go) begin
            rd_sh_q <= rd_word;
            rd_cnt_q <= 5'h00;
            out_bit_q <= 1'b0;
            drive_q <= 1'b1;
        end else if (in_read) begin
            out_bit_q <= rd_sh_q[15];
            rd_sh_q <= {rd_sh_q[14:0], 1'b0};
            rd_cnt_q <= rd_cnt_n;
        end
    end
    // Program enable latch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_q <= 1'b0;
        end else if (en_cmd) begin
            wr_en_q <= 1'b1;
        end else if (dis_cmd) begin
            wr_en_q <= 1'b0;
        end
    end
    // Deselect timer and status display
    wire desel_ok = (desel_cnt_q >= CSL_CYC_W);
    wire cs_rise = cs_s2 & ~cs_prev_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            desel_cnt_q <= 3'h0;
            cs_prev_q <= 1'b0;
            status_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_s2;
            if (cs_s2) begin
                desel_cnt_q <= 3'h0;
            end else if (!desel_ok) begin
                desel_cnt_q <= desel_cnt_q + 3'h1;
            end
            if (cs_rise && desel_ok && busy) begin
                status_q <= 1'b1;
            end else if (!cs_s2 || start_det) begin
                status_q <= 1'b0;
            end
        end
    end
    // Memory update at the start of each program cycle
    always_ff @(posedge clock) begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
            if (erase_all_cmd_go) begin
                mem[i] <= ERASED_WORD;
            end else if (write_all_cmd_go) begin
                mem[i] <= all_word;
            end
        end
        if (erase_go) begin
            mem[rd_idx] <= x16 ? ERASED_WORD :
                addr_n[0] ? {8'hFF, rd_word_raw[7:0]} :
                {rd_word_raw[15:8], 8'hFF};
        end else if (write_go) begin
            mem[wr_idx] <= merged;
        end
    end
    // Self-timed program cycle
    sep_prog_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(prog_go),
        .load(prog_load),
        .busy(busy)
    );
    // Pin drive: status or read data, else released
    assign serial_out_line = status_q ? ~busy : out_bit_q;
    assign serial_out_oe_n = ~(drive_q | status_q);
    assign standby = ~cs_s2 & ~busy;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    desel_reset_a: assert property (!cs_s2 |=> state_q == ST_IDLE)
        else $error("engine not reset while deselected");
    desel_release_a: assert property (!cs_s2 |=> serial_out_oe_n)
        else $error("output still driven after deselect");
    start_detect_a: assert property (start_det |=> state_q == ST_SHIFT)
        else $error("start bit not detected");
    idle_wait_a: assert property (state_q == ST_IDLE && cs_s2 && !di_s2
        |=> state_q == ST_IDLE)
        else $error("engine left idle without start");
    dummy_zero_a: assert property (read_go
        |=> !serial_out_oe_n && !serial_out_line)
        else $error("dummy zero missing before read data");
    read_bit_a: assert property (in_read && !status_q
        |=> serial_out_line == $past(rd_sh_q[15]))
        else $error("read bit does not follow word");
    prog_guard_a: assert property (prog_go |-> wr_en_q)
        else $error("programming started while disabled");
    status_val_a: assert property (cs_rise && desel_ok && busy
        |=> !serial_out_oe_n && serial_out_line == !busy)
        else $error("status level wrong");
    status_cause_a: assert property ($rose(status_q)
        |-> $past(desel_ok) && $past(busy))
        else $error("status shown without deselect");
    done_ignore_a: assert property (state_q == ST_DONE && cs_s2
        |=> state_q == ST_DONE)
        else $error("engine left done while selected");
    read_done_c: cover property (state_q == ST_READ ##1 state_q == ST_DONE);
    prog_start_c: cover property (prog_go);
    status_show_c: cover property ($rose(status_q));
    ready_seen_c: cover property (status_q && $fell(busy));
endmodule // sep_port
`default_nettype wire

/* dv/sep_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host controller on the far side of the three-wire link
module sep_host_model (
    input wire logic clock,
    input wire logic line_in,
    output logic device_select,
    output logic serial_clock,
    output logic serial_in_line
);
    logic [63:0] rx; // Line samples, one before each rise and one after the last fall

    // Clock rests low outside frames
    initial begin
        device_select = 1'b0;
        serial_clock = 1'b0;
        serial_in_line = 1'b0;
        rx = '0;
    end

    // Wait n core clocks, then step just off the edge
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Deselect for six clocks, past the least low time
    task automatic desel();
        device_select = 1'b0;
        tk(6);
    endtask

    // Raise select with setup before the first edge
    task automatic up();
        device_select = 1'b1;
        tk(6);
    endtask

    // Fresh instruction: deselect, then select again
    task automatic sel();
        desel();
        up();
    endtask

    // One rising edge per bit; high and low phases of 200 ns
    task automatic bits(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = v[i];
            tk(4);
            rx = {rx[62:0], line_in};
            serial_clock = 1'b1;
            tk(4);
            serial_clock = 1'b0;
        end
        // Data line is a don't-care now: leave it changed, not held
        serial_in_line = ~serial_in_line;
        tk(4);
        rx = {rx[62:0], line_in};
    endtask
endmodule // sep_host_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sep_pkg::*;
;
    localparam int WC = 200; // Shortened cycle lengths
    localparam int EC = 300;
    localparam int WL = 600;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic word_width_select = 1'b1; // Tied firmly, never floating
    logic device_select;
    logic serial_clock;
    logic serial_in_line;
    logic serial_out_line;
    logic serial_out_oe_n;
    logic standby;
    wire logic line_w;
    int n_errors = 0;
    int n_checks = 0;

    // Pull-up holds the released line high
    assign line_w = serial_out_oe_n ? 1'b1 : serial_out_line;
    always #25 clock = ~clock;

    sep_port #(.WC_CYC(WC), .EC_CYC(EC), .WL_CYC(WL)) DUT (
        .clock(clock),
        .resetn(resetn),
        .device_select(device_select),
        .serial_clock(serial_clock),
        .serial_in_line(serial_in_line),
        .word_width_select(word_width_select),
        .serial_out_line(serial_out_line),
        .serial_out_oe_n(serial_out_oe_n),
        .standby(standby)
    );

    sep_host_model HOST (
        .clock(clock),
        .line_in(line_w),
        .device_select(device_select),
        .serial_clock(serial_clock),
        .serial_in_line(serial_in_line)
    );

    // Verdict and end of run
    task automatic test_done();
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
            n_errors++;
        end
    endtask

    // Word reads and writes, start bit then opcode first
    task automatic rd16(input logic [6:0] a, input logic [15:0] d);
        HOST.sel();
        HOST.bits(64'({1'b1, OP_READ, a, 16'h0000}), 26);
        chk(HOST.rx[16:0], {1'b0, d});
    endtask

    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        HOST.sel();
        HOST.bits(64'({1'b1, OP_WRITE, a, d}), 26);
    endtask

    // Extended codes, with data only for the fill-all form
    task automatic ext(input logic [1:0] s, input logic [15:0] d);
        HOST.sel();
        if (s == EXT_WRITE_ALL_CMD)
            HOST.bits(64'({1'b1, OP_EXT, s, 5'h00, d}), 26);
        else
            HOST.bits(64'({1'b1, OP_EXT, s, 5'h00}), 10);
    endtask

    // Status poll: busy first, ready within the cycle limit
    task automatic poll(input int lim);
        int i;
        HOST.sel();
        chk({serial_out_oe_n, line_w}, 2'b00);
        for (i = 0; i < lim && line_w !== 1'b1; i++)
            HOST.tk(1);
        chk(i > lim - 60 && i < lim, 1'b1);
        if (i >= lim)
            test_done();
        HOST.desel();
        chk(serial_out_oe_n, 1'b1);
    endtask

    task automatic s_reset();
        chk({serial_out_oe_n, standby}, 2'b11);
    endtask

    // Enable, then write one word and watch status
    task automatic s_prog_word();
        ext(EXT_EN, 16'h0000);
        wr16(7'h05, 16'hC3A5);
        poll(WC);
    endtask

    // Clocks before start change nothing; extra clocks are ignored
    task automatic s_idle_read();
        HOST.bits(64'h7, 3);
        chk(standby, 1'b1);
        HOST.up();
        chk(standby, 1'b0);
        HOST.bits(64'h0, 5);
        chk(serial_out_oe_n, 1'b1);
        HOST.bits(64'({1'b1, OP_READ, 7'h05, 16'h0000, 3'b111}), 29);
        chk(HOST.rx[19:0], {1'b0, 16'hC3A5, 3'b111});
        HOST.desel();
        chk(serial_out_oe_n, 1'b1);
    endtask

    // Disabled programming is refused and shows no status
    task automatic s_protect();
        ext(EXT_DIS, 16'h0000);
        wr16(7'h05, 16'h0FF0);
        HOST.sel();
        chk(serial_out_oe_n, 1'b1);
        rd16(7'h05, 16'hC3A5);
    endtask

    // Select held high, then low, through a whole cycle
    task automatic s_hold_select();
        ext(EXT_EN, 16'h0000);
        wr16(7'h06, 16'h1357);
        HOST.tk(WC + 20);
        chk(serial_out_oe_n, 1'b1);
        wr16(7'h07, 16'h2468);
        HOST.desel();
        chk(standby, 1'b0);
        HOST.tk(WC);
        chk(standby, 1'b1);
        rd16(7'h06, 16'h1357);
        rd16(7'h07, 16'h2468);
    endtask

    // Erase all, fill all, single erase
    task automatic s_bulk();
        ext(EXT_ERASE_ALL_CMD, 16'h0000);
        poll(EC);
        rd16(7'h06, ERASED_WORD);
        ext(EXT_WRITE_ALL_CMD, 16'h5A0F);
        poll(WL);
        rd16(7'h7F, 16'h5A0F);
        HOST.sel();
        HOST.bits(64'({1'b1, OP_ERASE, 7'h03}), 10);
        poll(WC);
        rd16(7'h03, ERASED_WORD);
        rd16(7'h04, 16'h5A0F);
    endtask

    // Byte mode: odd address is the high byte of a word
    task automatic s_byte();
        HOST.desel();
        word_width_select = 1'b0;
        HOST.sel();
        HOST.bits(64'({1'b1, OP_WRITE, 8'h09, 8'h77}), 19);
        poll(WC);
        HOST.sel();
        HOST.bits(64'({1'b1, OP_READ, 8'h08, 8'h00}), 19);
        chk(HOST.rx[8:0], {1'b0, 8'h0F});
        // Byte erase clears only the addressed low byte
        HOST.sel();
        HOST.bits(64'({1'b1, OP_ERASE, 8'h08}), 11);
        poll(WC);
        HOST.desel();
        word_width_select = 1'b1;
        rd16(7'h04, 16'h77FF);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        s_reset();
        repeat (6) @(posedge clock);
        #1;
        resetn = 1'b1;
        HOST.tk(8);
        s_prog_word();
        s_idle_read();
        s_protect();
        s_hold_select();
        s_bulk();
        s_byte();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
